// file: common/ctm_pkg.sv
/*
 * Package for the compact timer: register indices, field positions, reset values,
 * clock select and mode codes, and the bus request carrier.
 * Assumes a byte-wide register port with one-cycle strobes.
 */
package ctm_pkg;
   localparam int          AW = 3;
   localparam logic [2:0]  REG_CTRL0   = 3'h0;
   localparam logic [2:0]  REG_CTRL1   = 3'h1;
   localparam logic [2:0]  REG_CNT_LO  = 3'h2;
   localparam logic [2:0]  REG_CNT_HI  = 3'h3;
   localparam logic [2:0]  REG_CMPA_LO = 3'h4;
   localparam logic [2:0]  REG_CMPA_HI = 3'h5;
   localparam logic [2:0]  REG_CMPP    = 3'h6;
   localparam logic [7:0]  CTRL0_RST   = 8'h00;
   localparam logic [7:0]  CTRL1_RST   = 8'h00;
   localparam logic [7:0]  CTRL0_MASK  = 8'hF8;
   localparam int          C0_PAUSE = 7;
   localparam int          C0_CKS_LO = 4;
   localparam int          C0_EN = 3;
   localparam int          C1_MODE_LO = 6;
   localparam int          C1_ACT_LO = 4;
   localparam int          C1_INIT = 3;
   localparam int          C1_INV = 2;
   localparam int          C1_SWAP = 1;
   localparam int          C1_CLRA = 0;
   localparam int          DIV_SYS4 = 4;
   localparam int          DIV_H16 = 16;
   localparam int          DIV_H64 = 64;
   localparam logic [1:0]  MODE_CMP = 2'b00;
   localparam logic [1:0]  MODE_PWM = 2'b10;
   localparam logic [1:0]  MODE_TMR = 2'b11;

   typedef enum logic [2:0] {
      CKS_SYS4 = 3'b000,
      CKS_SYS  = 3'b001,
      CKS_H16  = 3'b010,
      CKS_H64  = 3'b011,
      CKS_SUB0 = 3'b100,
      CKS_SUB1 = 3'b101,
      CKS_EXTR = 3'b110,
      CKS_EXTF = 3'b111
   } ctm_cks_t;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [7:0]    wdata;
      logic          wr;
      logic          rd;
   } ctm_req_t;
endpackage : ctm_pkg

// file: core/ctm_timer.sv
/*
 * Compact timer: 16-bit up counter, comparators A and P, compare, PWM and timer modes,
 * complementary output pins and buffered byte access to 16-bit values.
 * Assumes CLK is the system clock; the high and sub clock ticks and the external
 * count pin are asynchronous levels and are synchronised here.
 */
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ctm_timer
(
   input  wire logic              CLK,
   input  wire logic              RESET,
   input  wire ctm_pkg::ctm_req_t REQ,
   output logic [7:0]             RDATA,
   input  wire logic              HCLK_TICK,
   input  wire logic              SUBCLK_TICK,
   input  wire logic              EXT_COUNT_PIN,
   output logic                   TIMER_OUTPUT_PIN,
   output logic                   TIMER_OUTPUT_PIN_N,
   output logic                   COMPARE_A_MATCH_FLAG,
   output logic                   COMPARE_P_MATCH_FLAG
);
   import ctm_pkg::*;

   function automatic logic rise(input logic now, input logic was);
      rise = now & ~was;
   endfunction : rise

   logic [7:0]  ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d, buf_q, buf_d, rdata_q, rdata_d;
   logic [7:0]  cmpa_lo_q, cmpa_lo_d, cmpa_hi_q, cmpa_hi_d, cmpp_q, cmpp_d;
   logic [15:0] cnt_q, cnt_d;
   logic [1:0]  div4_q, div4_d;
   logic [3:0]  div16_q, div16_d;
   logic [5:0]  div64_q, div64_d;
   logic [2:0]  h_sync_q, s_sync_q, e_sync_q;
   logic        en_q, out_q, out_d, fa_q, fa_d, fp_q, fp_d;
   logic        tick, en_rise, match_a, match_p, ovf, clr, pwm_wave, pin;
   logic [15:0] cmpa, period, duty;
   logic [1:0]  mode, act;
   ctm_cks_t    cks;

   assign mode = ctrl1_q[C1_MODE_LO +: 2];
   assign act  = ctrl1_q[C1_ACT_LO +: 2];
   assign cks  = ctm_cks_t'(ctrl0_q[C0_CKS_LO +: 3]);
   assign cmpa = {cmpa_hi_q, cmpa_lo_q};
   assign en_rise = rise(ctrl0_q[C0_EN], en_q);

   // Register port.
   always_comb
   begin
      ctrl0_d   = ctrl0_q;
      ctrl1_d   = ctrl1_q;
      buf_d     = buf_q;
      cmpa_lo_d = cmpa_lo_q;
      cmpa_hi_d = cmpa_hi_q;
      cmpp_d    = cmpp_q;
      rdata_d   = 8'h00;
      if (REQ.wr)
      begin
         case (REQ.addr)
            REG_CTRL0:   ctrl0_d = REQ.wdata & CTRL0_MASK;
            REG_CTRL1:   ctrl1_d = REQ.wdata;
            REG_CMPA_LO: buf_d = REQ.wdata;
            REG_CMPA_HI:
            begin
               cmpa_hi_d = REQ.wdata;
               cmpa_lo_d = buf_q;
            end
            REG_CMPP:    cmpp_d = REQ.wdata;
            default:     ;
         endcase
      end
      else if (REQ.rd)
      begin
         case (REQ.addr)
            REG_CTRL0:   rdata_d = ctrl0_q;
            REG_CTRL1:   rdata_d = ctrl1_q;
            REG_CNT_HI:
            begin
               rdata_d = cnt_q[15:8];
               buf_d   = cnt_q[7:0];
            end
            REG_CMPA_HI:
            begin
               rdata_d = cmpa_hi_q;
               buf_d   = cmpa_lo_q;
            end
            REG_CNT_LO,
            REG_CMPA_LO: rdata_d = buf_q;
            REG_CMPP:    rdata_d = cmpp_q;
            default:     rdata_d = 8'h00;
         endcase
      end
   end

   // Clock tick generation; the prescalers run freely, and the enable and pause stop the counter only by gating ticks.
   always_comb
   begin
      div4_d  = div4_q + 2'd1;
      div16_d = div16_q;
      div64_d = div64_q;
      if (rise(h_sync_q[1], h_sync_q[2]))
      begin
         div16_d = div16_q + 4'd1;
         div64_d = div64_q + 6'd1;
      end
      case (cks)
         CKS_SYS4: tick = (div4_q == 2'(DIV_SYS4 - 1));
         CKS_SYS:  tick = 1'b1;
         CKS_H16:  tick = rise(h_sync_q[1], h_sync_q[2]) && (div16_q == 4'(DIV_H16 - 1));
         CKS_H64:  tick = rise(h_sync_q[1], h_sync_q[2]) && (div64_q == 6'(DIV_H64 - 1));
         CKS_SUB0,
         CKS_SUB1: tick = rise(s_sync_q[1], s_sync_q[2]);
         CKS_EXTR: tick = rise(e_sync_q[1], e_sync_q[2]);
         CKS_EXTF: tick = rise(e_sync_q[2], e_sync_q[1]);
         default:  tick = 1'b0;
      endcase
   end

   // Comparators and counter.
   always_comb
   begin
      match_a = (cnt_q == cmpa);
      // Matching one count early lets the clear land as the upper byte reaches the value.
      match_p = (cnt_q == {cmpp_q, 8'h00} - 16'd1) && (cmpp_q != 8'h00);
      ovf     = (cnt_q == 16'hFFFF) && (cmpp_q == 8'h00);
      if (mode == MODE_PWM)
         clr = ctrl1_q[C1_SWAP] ? match_a : (match_p | ovf);
      else
         clr = ctrl1_q[C1_CLRA] ? match_a : (match_p | ovf);
      cnt_d = cnt_q;
      fa_d  = 1'b0;
      fp_d  = 1'b0;
      out_d = out_q;
      if (en_rise)
      begin
         cnt_d = 16'h0000;
         out_d = ctrl1_q[C1_INIT];
      end
      else if (ctrl0_q[C0_EN] && !ctrl0_q[C0_PAUSE] && tick)
      begin
         cnt_d = clr ? 16'h0000 : cnt_q + 16'd1;
         fa_d  = match_a && (cmpa != 16'h0000 || mode == MODE_PWM);
         fp_d  = (match_p | (ovf && mode == MODE_PWM)) &&
                 (mode == MODE_PWM || !ctrl1_q[C1_CLRA]);
         if (mode == MODE_CMP && match_a && cmpa != 16'h0000)
         begin
            case (act)
               2'b01:   out_d = 1'b0;
               2'b10:   out_d = 1'b1;
               2'b11:   out_d = ~out_q;
               default: out_d = out_q;
            endcase
         end
      end
   end

   // The duty comparison uses the live counter so a duty above period gives 100%.
   always_comb
   begin
      period   = ctrl1_q[C1_SWAP] ? cmpa : {cmpp_q, 8'h00};
      duty     = ctrl1_q[C1_SWAP] ? {cmpp_q, 8'h00} : cmpa;
      pwm_wave = (cnt_q < duty) || (ctrl1_q[C1_SWAP] && cmpp_q == 8'h00);
      case (mode)
         MODE_CMP: pin = out_q;
         MODE_PWM:
         begin
            case (act)
               2'b00:   pin = ~ctrl1_q[C1_INIT];
               2'b01:   pin = ctrl1_q[C1_INIT];
               2'b10:   pin = pwm_wave ? ctrl1_q[C1_INIT] : ~ctrl1_q[C1_INIT];
               default: pin = 1'b0;
            endcase
         end
         default: pin = 1'b0;
      endcase
      if (mode != MODE_TMR && ctrl1_q[C1_INV])
         pin = ~pin;
   end

   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         ctrl0_q   <= CTRL0_RST;
         ctrl1_q   <= CTRL1_RST;
         buf_q     <= 8'h00;
         cmpa_lo_q <= 8'h00;
         cmpa_hi_q <= 8'h00;
         cmpp_q    <= 8'h00;
         rdata_q   <= 8'h00;
         cnt_q     <= 16'h0000;
         div4_q    <= 2'd0;
         div16_q   <= 4'd0;
         div64_q   <= 6'd0;
         h_sync_q  <= 3'd0;
         s_sync_q  <= 3'd0;
         e_sync_q  <= 3'd0;
         en_q      <= 1'b0;
         out_q     <= 1'b0;
         fa_q      <= 1'b0;
         fp_q      <= 1'b0;
      end
      else
      begin
         ctrl0_q   <= ctrl0_d;
         ctrl1_q   <= ctrl1_d;
         buf_q     <= buf_d;
         cmpa_lo_q <= cmpa_lo_d;
         cmpa_hi_q <= cmpa_hi_d;
         cmpp_q    <= cmpp_d;
         rdata_q   <= rdata_d;
         cnt_q     <= cnt_d;
         div4_q    <= div4_d;
         div16_q   <= div16_d;
         div64_q   <= div64_d;
         h_sync_q  <= {h_sync_q[1:0], HCLK_TICK};
         s_sync_q  <= {s_sync_q[1:0], SUBCLK_TICK};
         e_sync_q  <= {e_sync_q[1:0], EXT_COUNT_PIN};
         en_q      <= ctrl0_q[C0_EN];
         out_q     <= out_d;
         fa_q      <= fa_d;
         fp_q      <= fp_d;
      end
   end

   assign RDATA                = rdata_q;
   assign TIMER_OUTPUT_PIN     = pin;
   assign TIMER_OUTPUT_PIN_N   = ~pin;
   assign COMPARE_A_MATCH_FLAG = fa_q;
   assign COMPARE_P_MATCH_FLAG = fp_q;
endmodule : ctm_timer

// file: bench/ctm_timer_monitor.sv
/* Port checker for the compact timer.
   Assumes it is bound to ctm_timer and sees only its ports. */
`timescale 1ns/1ps
module ctm_monitor
(
   input wire logic              CLK,
   input wire logic              RESET,
   input wire ctm_pkg::ctm_req_t REQ,
   input wire logic [7:0]        RDATA,
   input wire logic              TIMER_OUTPUT_PIN,
   input wire logic              TIMER_OUTPUT_PIN_N,
   input wire logic              COMPARE_A_MATCH_FLAG,
   input wire logic              COMPARE_P_MATCH_FLAG
);
   import ctm_pkg::*;
   logic [7:0] c0_q, c0_d, c1_q, c1_d;
   logic       halt, clra;
   // Shadows of the control bytes, rebuilt from the write strobes alone.
   always_comb
   begin
      c0_d = (REQ.wr && REQ.addr == REG_CTRL0) ? REQ.wdata : c0_q;
      c1_d = (REQ.wr && REQ.addr == REG_CTRL1) ? REQ.wdata : c1_q;
   end
   always_ff @(posedge CLK)
   begin
      c0_q <= RESET ? CTRL0_RST : c0_d;
      c1_q <= RESET ? CTRL1_RST : c1_d;
   end
   assign halt = !c0_q[C0_EN] || c0_q[C0_PAUSE];
   assign clra = c1_q[C1_CLRA] && c1_q[7:6] != MODE_PWM;
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence s_en_up;
      REQ.wr && REQ.addr == REG_CTRL0 && REQ.wdata[C0_EN] && !c0_q[C0_EN];
   endsequence
   sequence s_rd_mode;
      REQ.rd && !REQ.wr && REQ.addr == REG_CTRL1;
   endsequence
   chk_pin_pair: assert property (TIMER_OUTPUT_PIN_N == !TIMER_OUTPUT_PIN)
      else $error("pins not complementary");
   chk_read_idle: assert property (!$past(REQ.rd) |-> RDATA == 8'h00)
      else $error("read data without read");
   chk_mode_read: assert property (s_rd_mode |=> RDATA == c1_q)
      else $error("mode byte read wrong");
   chk_a_pulse: assert property (COMPARE_A_MATCH_FLAG |=> !COMPARE_A_MATCH_FLAG)
      else $error("A flag too long");
   chk_p_silent: assert property ($past(clra) && $past(clra, 2) |-> !COMPARE_P_MATCH_FLAG)
      else $error("P flag with clear on A");
   chk_halt_quiet: assert property (
      $past(halt) && $past(halt, 2) |-> !COMPARE_A_MATCH_FLAG && !COMPARE_P_MATCH_FLAG)
      else $error("flag while halted");
   chk_en_init: assert property (
      s_en_up ##0 c1_q[7:6] == MODE_CMP |-> ##2 TIMER_OUTPUT_PIN == (c1_q[C1_INIT] ^ c1_q[C1_INV]))
      else $error("pin not at initial level");
   chk_pwm_force: assert property (
      c1_q[7:6] == MODE_PWM && !c1_q[5]
      |-> TIMER_OUTPUT_PIN == ((c1_q[C1_INIT] ~^ c1_q[C1_ACT_LO]) ^ c1_q[C1_INV]))
      else $error("forced PWM level wrong");
endmodule : ctm_monitor
bind ctm_timer ctm_monitor i_mon (.CLK(CLK), .RESET(RESET), .REQ(REQ), .RDATA(RDATA),
   .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .TIMER_OUTPUT_PIN_N(TIMER_OUTPUT_PIN_N),
   .COMPARE_A_MATCH_FLAG(COMPARE_A_MATCH_FLAG), .COMPARE_P_MATCH_FLAG(COMPARE_P_MATCH_FLAG));

// file: bench/test_ctm_timer.sv
/* Self-checking bench for the compact timer.
   Assumes a 250 MHz clock; clock sources and the count pin toggle freely here. */
`timescale 1ns/1ps
module test_ctm_timer;
   import ctm_pkg::*;
   typedef struct {logic w; logic [2:0] a; logic [7:0] d;} ctm_row_t;
   typedef struct {logic [7:0] m, c; int n, ea, ep, eh;} ctm_run_t;
   logic       clk = 1'h0, reset = 1'h1, hclk = 1'h0, sclk = 1'h0, ext = 1'h0;
   ctm_req_t   req = '0;
   logic [7:0] rdata;
   logic       pin, pin_n, fa, fp;
   int         fails = 0, total_checks = 0, cyc = 0, na, np, nh, i;
   ctm_row_t rows [22] = '{'{1'h0, 3'h0, 8'h00}, '{1'h0, 3'h1, 8'h00}, '{1'h1, 3'h4, 8'h34},
      '{1'h0, 3'h5, 8'h00}, '{1'h0, 3'h4, 8'h00}, '{1'h1, 3'h4, 8'h34}, '{1'h1, 3'h5, 8'h12},
      '{1'h0, 3'h5, 8'h12}, '{1'h0, 3'h4, 8'h34}, '{1'h1, 3'h3, 8'h55}, '{1'h0, 3'h3, 8'h00},
      '{1'h1, 3'h0, 8'hFF}, '{1'h0, 3'h0, 8'hF8}, '{1'h0, 3'h3, 8'h00}, '{1'h0, 3'h2, 8'h00},
      '{1'h1, 3'h0, 8'h00}, '{1'h0, 3'h7, 8'h00}, '{1'h1, 3'h6, 8'hAB}, '{1'h0, 3'h6, 8'hAB},
      '{1'h1, 3'h4, 8'h05}, '{1'h1, 3'h5, 8'h00}, '{1'h1, 3'h6, 8'h01}};
   ctm_run_t runs [14] = '{'{8'h00, 8'h18, 512, 2, 2, 0}, '{8'hC0, 8'h18, 512, 2, 2, -1},
      '{8'h01, 8'h18, 60, 1, 0, 0}, '{8'h00, 8'h08, 2048, 2, 2, 0},
      '{8'h00, 8'h28, 16384, 1, 1, 0}, '{8'h00, 8'h48, 5120, 2, 2, 0},
      '{8'h00, 8'h58, 5120, 2, 2, 0}, '{8'h00, 8'h68, 3072, 2, 2, 0},
      '{8'h00, 8'h78, 3072, 2, 2, 0}, '{8'hA8, 8'h18, 512, -1, -1, 128},
      '{8'hAC, 8'h18, 512, -1, -1, 384}, '{8'hAA, 8'h18, 512, -1, -1, 512},
      '{8'h88, 8'h18, 512, -1, -1, 0}, '{8'h98, 8'h18, 512, -1, -1, 512}};
   ctm_timer i_dut (.CLK(clk), .RESET(reset), .REQ(req), .RDATA(rdata), .HCLK_TICK(hclk),
      .SUBCLK_TICK(sclk), .EXT_COUNT_PIN(ext), .TIMER_OUTPUT_PIN(pin),
      .TIMER_OUTPUT_PIN_N(pin_n), .COMPARE_A_MATCH_FLAG(fa), .COMPARE_P_MATCH_FLAG(fp));
   always #2 clk = ~clk;
   always #8 hclk = ~hclk;
   always #20 sclk = ~sclk;
   always #12 ext = ~ext;
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check8
   task automatic check_n(input int got, input int exp);
      check8(8'(got != exp), 8'h00);
   endtask : check_n
   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
      @(posedge clk);
      req <= '0;
      #1;
   endtask : bus_wr
   // The answer stands only in the cycle after the strobe, so it is read just there.
   task automatic bus_rd(input logic [2:0] a, input logic [7:0] exp);
      req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
      @(posedge clk);
      req <= '0;
      #1;
      check8(rdata, exp);
   endtask : bus_rd
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 70000)
      begin
         fails++;
         stop_test();
      end
   end
   initial
   begin
      repeat (5) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      for (i = 0; i < 22; i++)
         if (rows[i].w)
            bus_wr(rows[i].a, rows[i].d);
         else
            bus_rd(rows[i].a, rows[i].d);
      $display("register access test done");
      for (i = 0; i < 4; i++)
      begin
         bus_wr(REG_CTRL0, 8'h00);
         bus_wr(REG_CTRL1, {2'h0, 2'(i), 4'h1});
         bus_wr(REG_CTRL0, 8'h18);
         for (na = 0; na < 40 && fa !== 1'h1; na++)
         begin
            @(posedge clk);
            #1;
         end
         repeat (2) @(posedge clk);
         check8({7'h00, pin}, {7'h00, i[1]});
      end
      $display("match action test done");
      for (i = 0; i < 14; i++)
      begin
         if (i == 9)
         begin
            bus_wr(REG_CMPA_LO, 8'h40);
            bus_wr(REG_CMPA_HI, 8'h00);
         end
         bus_wr(REG_CTRL0, 8'h00);
         bus_wr(REG_CTRL1, runs[i].m);
         bus_wr(REG_CTRL0, runs[i].c);
         repeat (8) @(posedge clk);
         na = 0;
         np = 0;
         nh = 0;
         repeat (runs[i].n)
         begin
            @(posedge clk);
            #1;
            na += 32'(fa);
            np += 32'(fp);
            nh += 32'(pin);
         end
         if (runs[i].ea >= 0)
            check_n(32'(na != 0), 32'(runs[i].ea != 0));
         if (runs[i].ep >= 0)
            check_n(np, runs[i].ep);
         if (runs[i].eh >= 0)
            check_n(nh, runs[i].eh);
         $display("counting run %0d done", i);
      end
      @(posedge clk);
      reset <= 1'h1;
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      #1;
      check8({4'h0, pin, pin_n, fa, fp}, 8'h04);
      bus_rd(REG_CTRL1, 8'h00);
      $display("reset test done");
      stop_test();
   end
endmodule : test_ctm_timer
